// file: pxb_pkg.sv
package pxb_pkg;
  // ==========================================================================
  // register placement
  localparam logic [7:0] STATUS_OFFSET = 8'h84;
  localparam int REG_INDEX_LSB = 2;
  localparam int REG_INDEX_MSB = 7;

  // ==========================================================================
  // configuration address phase fields
  localparam int AD_TYPE_LSB = 0;
  localparam int AD_TYPE_MSB = 1;
  localparam int AD_FUNC_LSB = 8;
  localparam int AD_FUNC_MSB = 10;
  localparam int AD_DEV_LSB = 11;
  localparam int AD_DEV_MSB = 15;
  localparam logic [1:0] AD_TYPE0 = 2'h0;

  // configuration commands
  localparam logic [3:0] CMD_CFG_READ = 4'ha;
  localparam logic [3:0] CMD_CFG_WRITE = 4'hb;

  // ==========================================================================
  // status field layout
  localparam int FUNC_LSB = 0;
  localparam int FUNC_MSB = 2;
  localparam int DEV_LSB = 3;
  localparam int DEV_MSB = 7;
  localparam int BUS_LSB = 8;
  localparam int BUS_MSB = 15;
  localparam int WIDE_BIT = 16;
  localparam int FAST_BIT = 17;
  localparam int DISCARD_BIT = 18;
  localparam int UNEXPECTED_BIT = 19;
  localparam int OVERRUN_BIT = 20;
  localparam int DELAYED_BIT = 21;
  localparam int FLAG_LANE = 2;

  // ==========================================================================
  // reset values
  localparam logic [2:0] FUNC_RESET = 3'h0;
  localparam logic [4:0] DEV_RESET = 5'h1f;
  localparam logic [7:0] BUS_RESET = 8'hff;
  localparam logic [31:0] DATA_ZERO = 32'h0;

  // function this device answers as (single function device)
  localparam logic [2:0] OWN_FUNCTION = 3'h0;
endpackage : pxb_pkg

// file: pxb_sync2.sv
`timescale 1ns/10ps
`default_nettype none
module pxb_sync2 (
  input wire logic clock,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic stage1;
  logic next_stage1;
  logic next_q;

  always_comb begin
    next_stage1 = d;
    next_q = stage1;
    if (rst) begin
      next_stage1 = 1'b0;
      next_q = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    stage1 <= next_stage1;
    q <= next_q;
  end
endmodule : pxb_sync2
`default_nettype wire

// file: pxb_flag.sv
`timescale 1ns/10ps
`default_nettype none
module pxb_flag (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic setEvent,
  input wire logic clearReq,
  output logic q
);
  logic next_q;

  // set wins over a clear in the same cycle; disabled flag holds zero
  always_comb begin
    next_q = q;
    if (clearReq) begin
      next_q = 1'b0;
    end
    if (setEvent) begin
      next_q = 1'b1;
    end
    if (rst || !enable) begin
      next_q = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    q <= next_q;
  end
endmodule : pxb_flag
`default_nettype wire

// file: pxb_primary_status.sv
`timescale 1ns/10ps
`default_nettype none
module pxb_primary_status
  import pxb_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  // bridge mode and reset-time pins (asynchronous)
  input wire logic reverseMode,
  input wire logic wide_device_strap,
  input wire logic wide_request_line_low,
  // configuration transaction from the primary target front end
  input wire logic cfgStrobe,
  input wire logic [3:0] cfgCommand,
  input wire logic cfgSelect,
  input wire logic [31:0] cfgAddress,
  input wire logic [3:0] cfgByteEnable,
  input wire logic [31:0] cfgWriteData,
  output logic cfgHit,
  output logic [31:0] cfgReadData,
  output logic cfgReadValid,
  // primary bus number from the type 1 header
  input wire logic [7:0] primaryBusNumber,
  // interface modes
  input wire logic primaryIsPcix,
  input wire logic secondaryIsPcix,
  // split transaction events
  input wire logic completionDiscarded,
  input wire logic unexpectedCompletion,
  input wire logic [15:0] unexpectedRequesterId,
  input wire logic completionOverrun,
  input wire logic requestDelayed,
  // identity for split completions
  output logic [15:0] completerId,
  output logic mixedModeIdUse,
  // status register view
  output logic [31:0] statusValue
);
  // ==========================================================================
  // pin synchronisers
  // reset clears both stages, so synced pins lag release by two edges
  logic reverseSync;
  logic wideStrapSync;
  logic requestLowSync;

  pxb_sync2 u_syncReverse (
    .clock(clock),
    .rst(rst),
    .d(reverseMode),
    .q(reverseSync)
  );

  pxb_sync2 u_syncStrap (
    .clock(clock),
    .rst(rst),
    .d(wide_device_strap),
    .q(wideStrapSync)
  );

  pxb_sync2 u_syncRequest (
    .clock(clock),
    .rst(rst),
    .d(wide_request_line_low),
    .q(requestLowSync)
  );

  // ==========================================================================
  // configuration decode
  logic typeZero;
  logic functionMatch;
  logic addressed;
  logic writeAddressed;
  logic readAddressed;
  logic statusSelected;
  logic [5:0] regIndex;

  // addressed only with select, type 0 and our function
  always_comb begin
    typeZero = cfgAddress[AD_TYPE_MSB:AD_TYPE_LSB] == AD_TYPE0;
    functionMatch = cfgAddress[AD_FUNC_MSB:AD_FUNC_LSB] == OWN_FUNCTION;
    addressed = cfgStrobe && cfgSelect && typeZero && functionMatch;
    writeAddressed = addressed && (cfgCommand == CMD_CFG_WRITE);
    readAddressed = addressed && (cfgCommand == CMD_CFG_READ);
    regIndex = cfgAddress[REG_INDEX_MSB:REG_INDEX_LSB];
    statusSelected = regIndex == STATUS_OFFSET[REG_INDEX_MSB:REG_INDEX_LSB];
  end

  // ==========================================================================
  // identity fields
  logic [2:0] functionId;
  logic [4:0] deviceId;
  logic [7:0] busId;
  logic [2:0] next_functionId;
  logic [4:0] next_deviceId;
  logic [7:0] next_busId;

  always_comb begin
    next_functionId = functionId;
    next_deviceId = deviceId;
    next_busId = primaryBusNumber;
    if (writeAddressed) begin
      // device field from any addressed write
      next_deviceId = cfgAddress[AD_DEV_MSB:AD_DEV_LSB];
      next_functionId = cfgAddress[AD_FUNC_MSB:AD_FUNC_LSB];
    end
    if (rst) begin
      next_functionId = FUNC_RESET;
      next_deviceId = DEV_RESET;
      next_busId = BUS_RESET;
    end
  end

  always_ff @(posedge clock) begin
    functionId <= next_functionId;
    deviceId <= next_deviceId;
    busId <= next_busId;
  end

  // ==========================================================================
  // capability bits
  logic rstSeen;
  logic settleA;
  logic settleB;
  logic captureNow;
  logic wideCaptured;
  logic wideBit;
  logic fastBit;
  logic next_rstSeen;
  logic next_settleA;
  logic next_settleB;
  logic next_wideCaptured;
  logic next_wideBit;
  logic next_fastBit;

  // sample request line as it stood at release
  // synced copy is only valid two edges later, so capture then
  always_comb begin
    next_rstSeen = rst;
    next_settleA = rstSeen;
    next_settleB = settleA;
    captureNow = settleB && !settleA;
    next_wideCaptured = wideCaptured;
    if (captureNow) begin
      next_wideCaptured = requestLowSync;
    end
    if (rst) begin
      next_wideCaptured = 1'b0;
    end
  end

  always_comb begin
    // strap sets wide support in forward mode
    next_wideBit = wideStrapSync;
    if (reverseSync) begin
      // reverse mode uses captured request line
      next_wideBit = wideCaptured;
    end
    // fast capable only in reverse mode
    next_fastBit = reverseSync;
    if (rst) begin
      next_wideBit = 1'b0;
      next_fastBit = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    rstSeen <= next_rstSeen;
    settleA <= next_settleA;
    settleB <= next_settleB;
    wideCaptured <= next_wideCaptured;
    wideBit <= next_wideBit;
    fastBit <= next_fastBit;
  end

  // ==========================================================================
  // sticky split flags
  logic clearLane;
  logic discardFlag;
  logic unexpectedFlag;
  logic overrunFlag;
  logic delayedFlag;
  logic unexpectedMatch;

  always_comb begin
    clearLane = writeAddressed && statusSelected && cfgByteEnable[FLAG_LANE];
    // requester must equal our bus, device, function
    unexpectedMatch = unexpectedCompletion && (unexpectedRequesterId == completerId);
  end

  pxb_flag u_flagDiscard (
    .clock(clock),
    .rst(rst),
    .enable(!reverseSync),
    .setEvent(completionDiscarded),
    .clearReq(clearLane && cfgWriteData[DISCARD_BIT]),
    .q(discardFlag)
  );

  pxb_flag u_flagUnexpected (
    .clock(clock),
    .rst(rst),
    .enable(reverseSync),
    .setEvent(unexpectedMatch),
    .clearReq(clearLane && cfgWriteData[UNEXPECTED_BIT]),
    .q(unexpectedFlag)
  );

  pxb_flag u_flagOverrun (
    .clock(clock),
    .rst(rst),
    .enable(1'b1),
    .setEvent(completionOverrun),
    .clearReq(clearLane && cfgWriteData[OVERRUN_BIT]),
    .q(overrunFlag)
  );

  // delayed flag; limit lives upstream, event arrives ready-made
  pxb_flag u_flagDelayed (
    .clock(clock),
    .rst(rst),
    .enable(1'b1),
    .setEvent(requestDelayed),
    .clearReq(clearLane && cfgWriteData[DELAYED_BIT]),
    .q(delayedFlag)
  );

  // ==========================================================================
  // status word and completer identity
  logic [31:0] statusWord;

  always_comb begin
    statusWord = DATA_ZERO;
    statusWord[FUNC_MSB:FUNC_LSB] = functionId;
    statusWord[DEV_MSB:DEV_LSB] = deviceId;
    statusWord[BUS_MSB:BUS_LSB] = busId;
    statusWord[WIDE_BIT] = wideBit;
    statusWord[FAST_BIT] = fastBit;
    statusWord[DISCARD_BIT] = discardFlag;
    statusWord[UNEXPECTED_BIT] = unexpectedFlag;
    statusWord[OVERRUN_BIT] = overrunFlag;
    statusWord[DELAYED_BIT] = delayedFlag;
  end

  // completer ID from bus, device, function
  always_comb begin
    completerId = {busId, deviceId, functionId};
    // identity also used in mixed mode
    mixedModeIdUse = primaryIsPcix ^ secondaryIsPcix;
    statusValue = statusWord;
  end

  // ==========================================================================
  // configuration read answer
  logic [31:0] next_cfgReadData;
  logic next_cfgReadValid;
  logic next_cfgHit;

  // any addressed read answers; only the status index returns data
  always_comb begin
    next_cfgReadData = DATA_ZERO;
    next_cfgReadValid = readAddressed;
    next_cfgHit = addressed && statusSelected;
    if (readAddressed && statusSelected) begin
      next_cfgReadData = statusWord;
    end
    if (rst) begin
      next_cfgReadData = DATA_ZERO;
      next_cfgReadValid = 1'b0;
      next_cfgHit = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    cfgReadData <= next_cfgReadData;
    cfgReadValid <= next_cfgReadValid;
    cfgHit <= next_cfgHit;
  end
endmodule : pxb_primary_status
`default_nettype wire

// file: pxb_chk.sv
`timescale 1ns/10ps
`default_nettype none
module pxb_chk
  import pxb_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic cfgStrobe,
  input wire logic [3:0] cfgCommand,
  input wire logic cfgSelect,
  input wire logic [31:0] cfgAddress,
  input wire logic cfgHit,
  input wire logic cfgReadValid,
  input wire logic [7:0] primaryBusNumber,
  input wire logic primaryIsPcix,
  input wire logic secondaryIsPcix,
  input wire logic completionOverrun,
  input wire logic requestDelayed,
  input wire logic [15:0] completerId,
  input wire logic mixedModeIdUse,
  input wire logic [31:0] statusValue
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // ==========
  // addressed phases
  sequence adr_s;
    cfgStrobe && cfgSelect && cfgAddress[1:0] == AD_TYPE0 && cfgAddress[10:8] == OWN_FUNCTION;
  endsequence
  sequence wr_s;
    adr_s ##0 cfgCommand == CMD_CFG_WRITE;
  endsequence
  dev_load_a: assert property (wr_s |=> statusValue[7:3] == $past(cfgAddress[15:11]))
    else $error("device field not loaded");
  read_answer_a: assert property (adr_s ##0 cfgCommand == CMD_CFG_READ |=> cfgReadValid)
    else $error("read not answered");
  hit_reg_a: assert property (adr_s ##0 cfgAddress[7:2] == 6'h21 |=> cfgHit)
    else $error("status access missed");
  idle_quiet_a: assert property (!cfgStrobe |=> !cfgReadValid)
    else $error("answer without request");
  func_zero_a: assert property (statusValue[2:0] == 3'h0)
    else $error("function field wrong");
  bus_mirror_a: assert property (!$past(rst) |-> statusValue[15:8] == $past(primaryBusNumber))
    else $error("bus field wrong");
  comp_id_a: assert property (completerId == statusValue[15:0])
    else $error("completer id wrong");
  mixed_use_a: assert property (mixedModeIdUse == (primaryIsPcix ^ secondaryIsPcix))
    else $error("mixed mode flag wrong");
  discard_rev_a: assert property (statusValue[17] |-> !statusValue[18])
    else $error("discard flag in reverse");
  unexp_fwd_a: assert property (!statusValue[17] |-> !statusValue[19])
    else $error("unexpected flag in forward");
  overrun_set_a: assert property (completionOverrun |=> statusValue[20])
    else $error("overrun flag not set");
  delay_set_a: assert property (requestDelayed |=> statusValue[21])
    else $error("delayed flag not set");
  reserved_zero_a: assert property (statusValue[31:22] == 10'h0)
    else $error("reserved bits set");
endmodule : pxb_chk
bind pxb_primary_status pxb_chk chk_u (.clock, .rst, .cfgStrobe, .cfgCommand, .cfgSelect, .cfgAddress,
  .cfgHit, .cfgReadValid, .primaryBusNumber, .primaryIsPcix, .secondaryIsPcix, .completionOverrun,
  .requestDelayed, .completerId, .mixedModeIdUse, .statusValue);
`default_nettype wire

// file: pxb_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module pxb_host_model
  import pxb_pkg::*;
(
  input wire logic clock,
  input wire logic [31:0] cfgReadData,
  output logic cfgStrobe,
  output logic [3:0] cfgCommand,
  output logic cfgSelect,
  output logic [31:0] cfgAddress,
  output logic [3:0] cfgByteEnable,
  output logic [31:0] cfgWriteData
);
  initial begin
    cfgStrobe = 1'b0;
    cfgCommand = 4'h0;
    cfgSelect = 1'b0;
    cfgAddress = 32'h0;
    cfgByteEnable = 4'h0;
    cfgWriteData = 32'h0;
  end
  // ==========
  // type 0 config phase
  task automatic access(input logic wr, input logic sel, input logic [4:0] dev, input logic [5:0] idx,
    input logic [3:0] be, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock);
    cfgStrobe <= 1'b1;
    cfgCommand <= wr ? CMD_CFG_WRITE : CMD_CFG_READ;
    cfgSelect <= sel;
    cfgAddress <= {16'h0, dev, OWN_FUNCTION, idx, AD_TYPE0};
    cfgByteEnable <= be;
    cfgWriteData <= wd;
    @(posedge clock);
    cfgStrobe <= 1'b0;
    cfgAddress <= ~cfgAddress;
    cfgWriteData <= ~cfgWriteData;
    #1 rd = cfgReadData;
  endtask : access
endmodule : pxb_host_model
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import pxb_pkg::*;
;
  logic clock = 1'b0, rst = 1'b1, reverseMode = 1'b0, wide_device_strap = 1'b0, wide_request_line_low = 1'b0;
  logic discard = 1'b0, unexp = 1'b0, overrun = 1'b0, delayed = 1'b0, pPcix = 1'b0, sPcix = 1'b0;
  logic [15:0] reqId = 16'h0;
  logic [7:0] busNum = 8'h5a;
  logic cfgStrobe, cfgSelect, cfgHit, cfgReadValid, mixedModeIdUse;
  logic [3:0] cfgCommand, cfgByteEnable;
  logic [31:0] cfgAddress, cfgWriteData, cfgReadData, statusValue, rd;
  logic [15:0] completerId;
  int n_mismatch = 0, n_compared = 0;
  initial forever #25 clock = ~clock;
  pxb_host_model host_u (.clock, .cfgReadData, .cfgStrobe, .cfgCommand, .cfgSelect, .cfgAddress,
    .cfgByteEnable, .cfgWriteData);
  pxb_primary_status dut_u (.clock, .rst, .reverseMode, .wide_device_strap, .wide_request_line_low,
    .cfgStrobe, .cfgCommand, .cfgSelect, .cfgAddress, .cfgByteEnable, .cfgWriteData, .cfgHit,
    .cfgReadData, .cfgReadValid, .primaryBusNumber(busNum), .primaryIsPcix(pPcix), .secondaryIsPcix(sPcix),
    .completionDiscarded(discard), .unexpectedCompletion(unexp), .unexpectedRequesterId(reqId),
    .completionOverrun(overrun), .requestDelayed(delayed), .completerId, .mixedModeIdUse, .statusValue);
  // ==========
  // access and check tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic sel, input logic [4:0] dev, input logic [5:0] idx, input logic [3:0] be,
    input logic [31:0] wd);
    host_u.access(1'b1, sel, dev, idx, be, wd, rd);
  endtask : wr
  task automatic rdchk(input string nm, input logic [4:0] dev, input logic [5:0] fl);
    host_u.access(1'b0, 1'b1, 5'h0b, 6'h21, 4'hf, 32'h0, rd);
    chk(nm, {10'h0, fl, busNum, dev, 3'h0}, rd);
    chk("status valid", 32'h1, {31'h0, cfgReadValid});
    chk("status hit", 32'h1, {31'h0, cfgHit});
  endtask : rdchk
  task automatic ev(input logic [3:0] e, input logic [15:0] id);
    @(posedge clock);
    {discard, unexp, overrun, delayed} <= e;
    reqId <= id;
    @(posedge clock);
    {discard, unexp, overrun, delayed} <= 4'h0;
  endtask : ev
  task automatic do_reset;
    @(posedge clock);
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : do_reset
  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (4000) @(posedge clock);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    do_reset();
    rdchk("reset word", 5'h1f, 6'h00);
    wr(1'b0, 5'h03, 6'h10, 4'h0, 32'h0);
    rdchk("unselected write", 5'h1f, 6'h00);
    wr(1'b1, 5'h0b, 6'h10, 4'h0, 32'h0);
    rdchk("device load", 5'h0b, 6'h00);
    host_u.access(1'b0, 1'b1, 5'h0b, 6'h10, 4'hf, 32'h0, rd);
    chk("other index data", DATA_ZERO, rd);
    chk("other index valid", 32'h1, {31'h0, cfgReadValid});
    chk("other index hit", 32'h0, {31'h0, cfgHit});
    chk("completer id", {16'h0, busNum, 5'h0b, 3'h0}, {16'h0, completerId});
    ev(4'hf, {busNum, 5'h0b, 3'h0});
    rdchk("forward events", 5'h0b, 6'h34);
    wr(1'b1, 5'h0b, 6'h21, 4'hb, 32'h003c0000);
    rdchk("lane off", 5'h0b, 6'h34);
    wr(1'b1, 5'h0b, 6'h21, 4'h4, 32'h00100000);
    rdchk("clear one", 5'h0b, 6'h24);
    wr(1'b1, 5'h0b, 6'h21, 4'h4, 32'hffffffff);
    rdchk("clear all", 5'h0b, 6'h00);
    @(posedge clock);
    wide_device_strap <= 1'b1;
    repeat (5) @(posedge clock);
    rdchk("strap high", 5'h0b, 6'h01);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      {pPcix, sPcix} <= i[1:0];
      @(posedge clock);
      #1 chk("mixed use", {31'h0, i[1] ^ i[0]}, {31'h0, mixedModeIdUse});
    end
    @(posedge clock);
    reverseMode <= 1'b1;
    wide_device_strap <= 1'b0;
    wide_request_line_low <= 1'b1;
    do_reset();
    rdchk("reverse reset", 5'h1f, 6'h03);
    ev(4'hc, 16'h1234);
    rdchk("reverse ignored", 5'h1f, 6'h03);
    ev(4'h4, {busNum, 5'h1f, 3'h0});
    rdchk("reverse match", 5'h1f, 6'h0b);
    @(posedge clock);
    wide_request_line_low <= 1'b0;
    do_reset();
    rdchk("request high", 5'h1f, 6'h02);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
